/* pkg/ssc_pkg.sv */
// Shared constants, register map and carrier types of the status and startup block.
// Assumes a single 40 MHz clock; all users import the whole package.
package ssc_pkg;
   // Timing
   localparam int unsigned CLK_KHZ = 40000;
   localparam int unsigned FLASH_FAST_MS = 100;
   localparam int unsigned FLASH_SLOW_MS = 500;
   localparam int unsigned FAST_HALF_CYC = FLASH_FAST_MS * CLK_KHZ;
   localparam int unsigned SLOW_PER_FAST = FLASH_SLOW_MS / FLASH_FAST_MS;

   // Register byte offsets
   localparam logic [11:0] OFS_SETUP_M = 12'h000;
   localparam logic [11:0] OFS_SETUP_M1 = 12'h004;
   localparam logic [11:0] OFS_STATUS = 12'h008;
   localparam logic [11:0] OFS_COMMAND = 12'h00c;

   // Setup word fields and codes
   localparam int unsigned LOAD_CODE_LSB = 8;
   localparam int unsigned START_MODE_LSB = 0;
   localparam logic [7:0] CODE_ENABLE = 8'h5a;
   localparam logic [7:0] START_MANUAL = 8'h00;
   localparam logic [15:0] SETUP_RST = 16'h0000;

   // Status word bit positions
   localparam int unsigned SW_ERR = 2;
   localparam int unsigned SW_TERM = 3;
   localparam int unsigned SW_RX1 = 4;
   localparam int unsigned SW_RX2 = 5;
   localparam int unsigned SW_BATT = 6;
   localparam int unsigned SW_RUN = 7;
   localparam int unsigned STATUS_RUNSTATE = 16;

   // Command register bits (write one to act)
   localparam int unsigned CMD_ATTN = 0;
   localparam int unsigned CMD_RUN = 1;
   localparam int unsigned CMD_RESTART = 2;

   typedef enum {CT_BOOT, CT_STOP, CT_RUN} ssc_ctl_e;

   typedef struct packed {
      logic sysErr;
      logic progErr;
      logic battLow;
      logic hostPowerOff;
      logic cpuFault;
      logic memCorrupt;
      logic [2:0] rxErr;
      logic [2:0] portActive;
      logic waitInput;
      logic waitPrint;
      logic waitSend;
      logic waitCmd;
      logic xferWait;
      logic breakHit;
      logic stopStmt;
      logic runToHit;
   } ssc_cond_s;

   typedef struct packed {
      logic run;
      logic prog;
      logic err;
      logic [2:0] portErr;
      logic [2:0] portAct;
   } ssc_lamp_s;
endpackage

/* rtl/ssc_status_ctl.sv */
// Lamp drive, status word and program start control of the serial module.
// Assumes synchronous condition inputs from port logic and interpreter; APB slave.
`timescale 1ns/1ps
`default_nettype none
module ssc_status_ctl
   import ssc_pkg::*;
#(
   parameter bit THREE_PORT = 1'b1,
   parameter int unsigned FAST_CYC = FAST_HALF_CYC,
   parameter int unsigned SLOW_DIV = SLOW_PER_FAST
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic switchStart,
   input wire ssc_cond_s cond,
   output ssc_lamp_s lamp,
   output logic [15:0] statusWord,
   output logic programRun,
   output logic startPulse,
   output logic loadPulse
);
   if (FAST_CYC < 1 || SLOW_DIV < 1) begin : g_chk
      $error("Flash divider parameters must be at least one");
   end

   ////////////////////////////////////////////////////////////////////////
   // APB slave, zero wait states; read data captured in the setup cycle
   logic [15:0] setupM_reg, setupM_next, setupM1_reg, setupM1_next;
   logic [31:0] rdata_reg, rdata_next;
   logic [2:0] cmd;
   logic hit, wrAcc;
   ssc_ctl_e state_reg, state_next;

   always_comb begin
      hit = (paddr == OFS_SETUP_M) || (paddr == OFS_SETUP_M1) ||
            (paddr == OFS_STATUS) || (paddr == OFS_COMMAND);
      wrAcc = psel && penable && pwrite;
      setupM_next = setupM_reg;
      setupM1_next = setupM1_reg;
      rdata_next = rdata_reg;
      cmd = 3'h0;
      if (wrAcc && paddr == OFS_SETUP_M) begin
         setupM_next = pwdata[15:0];
      end
      if (wrAcc && paddr == OFS_SETUP_M1) begin
         setupM1_next = pwdata[15:0];
      end
      if (wrAcc && paddr == OFS_COMMAND) begin
         cmd = pwdata[2:0];
      end
      if (psel && !penable && !pwrite) begin
         case (paddr)
            OFS_SETUP_M: rdata_next = {16'h0000, setupM_reg};
            OFS_SETUP_M1: rdata_next = {16'h0000, setupM1_reg};
            OFS_STATUS: rdata_next = {15'h0000, programRun, statusWord};
            default: rdata_next = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         setupM_reg <= SETUP_RST;
         setupM1_reg <= SETUP_RST;
         rdata_reg <= 32'h00000000;
      end else begin
         setupM_reg <= setupM_next;
         setupM1_reg <= setupM1_next;
         rdata_reg <= rdata_next;
      end
   end

   assign prdata = rdata_reg;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !hit;

   ////////////////////////////////////////////////////////////////////////
   // Flash timebase: fast phase toggles once per fast half period
   logic [31:0] div_reg, div_next;
   logic [31:0] slowCnt_reg, slowCnt_next;
   logic fastPh_reg, fastPh_next, slowPh_reg, slowPh_next;

   always_comb begin
      div_next = div_reg + 32'h1;
      fastPh_next = fastPh_reg;
      slowCnt_next = slowCnt_reg;
      slowPh_next = slowPh_reg;
      if (div_reg >= 32'(FAST_CYC - 1)) begin
         div_next = 32'h0;
         fastPh_next = !fastPh_reg;
         slowCnt_next = slowCnt_reg + 32'h1;
         if (slowCnt_reg >= 32'(SLOW_DIV - 1)) begin
            slowCnt_next = 32'h0;
            slowPh_next = !slowPh_reg;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         div_reg <= 32'h0;
         slowCnt_reg <= 32'h0;
         fastPh_reg <= 1'b0;
         slowPh_reg <= 1'b0;
      end else begin
         div_reg <= div_next;
         slowCnt_reg <= slowCnt_next;
         fastPh_reg <= fastPh_next;
         slowPh_reg <= slowPh_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Start/stop control
   logic swPrev_reg, swPrev_next, attn_reg, attn_next;
   logic startP_next, loadP_next, autoMode, setupBad, haltReq;
   logic [7:0] startMode, loadCode;

   always_comb begin
      startMode = setupM1_reg[START_MODE_LSB +: 8];
      loadCode = setupM_reg[LOAD_CODE_LSB +: 8];
      autoMode = (startMode == CODE_ENABLE);
      setupBad = (startMode != CODE_ENABLE) && (startMode != START_MANUAL);
      haltReq = cmd[CMD_ATTN] || (swPrev_reg && !switchStart) ||
                cond.breakHit || cond.stopStmt || cond.runToHit;
      state_next = state_reg;
      swPrev_next = switchStart;
      attn_next = attn_reg || cmd[CMD_ATTN];
      startP_next = 1'b0;
      loadP_next = 1'b0;
      case (state_reg)
         CT_BOOT: begin
            // A key arriving in the boot cycle itself still arms the lamp
            attn_next = cmd[CMD_ATTN];
            loadP_next = (loadCode == CODE_ENABLE);
            // Auto start only with the switch at start
            if (autoMode && switchStart) begin
               state_next = CT_RUN;
               startP_next = 1'b1;
            end else begin
               state_next = CT_STOP;
            end
         end
         CT_STOP: begin
            // Switch edge or run command; both need the switch at start
            if (switchStart && (!swPrev_reg || cmd[CMD_RUN]) && !setupBad) begin
               state_next = CT_RUN;
               startP_next = 1'b1;
            end
         end
         CT_RUN: begin
            if (haltReq || !switchStart) begin
               state_next = CT_STOP;
            end
         end
         default: state_next = CT_BOOT;
      endcase
      // Restart reruns the boot evaluation from any state
      if (cmd[CMD_RESTART]) begin
         state_next = CT_BOOT;
         startP_next = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_reg <= CT_BOOT;
         swPrev_reg <= 1'b0;
         attn_reg <= 1'b0;
         startPulse <= 1'b0;
         loadPulse <= 1'b0;
      end else begin
         state_reg <= state_next;
         swPrev_reg <= swPrev_next;
         attn_reg <= attn_next;
         startPulse <= startP_next;
         loadPulse <= loadP_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Lamps and status word, both registered from the same conditions
   ssc_lamp_s lamp_next;
   logic [15:0] status_next;
   logic running, waiting, anyErr;
   logic [2:0] rxMask;

   always_comb begin
      running = (state_reg == CT_RUN);
      waiting = cond.waitInput || cond.waitPrint || cond.waitSend || cond.waitCmd;
      anyErr = cond.sysErr || cond.progErr;
      rxMask = {THREE_PORT, 2'b11};
      lamp_next = '0;
      status_next = 16'h0000;
      lamp_next.run = !(cond.sysErr || cond.hostPowerOff ||
                        cond.cpuFault || setupBad);
      if (running) begin
         lamp_next.prog = waiting ? slowPh_reg : 1'b1;
         status_next[SW_RUN] = !(cond.waitInput || cond.waitPrint);
      end else if (cond.xferWait) begin
         lamp_next.prog = fastPh_reg;
      end else if (attn_reg) begin
         lamp_next.prog = slowPh_reg;
      end else begin
         lamp_next.prog = 1'b0;
      end
      if (cond.memCorrupt) begin
         lamp_next.err = slowPh_reg;
         lamp_next.portErr = {3{slowPh_reg}} & rxMask;
      end else begin
         lamp_next.err = anyErr || (cond.battLow && slowPh_reg);
         lamp_next.portErr = cond.rxErr & rxMask;
      end
      lamp_next.portAct = cond.portActive & rxMask & {3{fastPh_reg}};
      status_next[SW_ERR] = anyErr;
      status_next[SW_BATT] = cond.battLow;
      status_next[SW_RX1] = cond.rxErr[0];
      status_next[SW_RX2] = cond.rxErr[1];
      status_next[SW_TERM] = cond.rxErr[2] && THREE_PORT;
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         lamp <= '0;
         statusWord <= 16'h0000;
         programRun <= 1'b0;
      end else begin
         lamp <= lamp_next;
         statusWord <= status_next;
         programRun <= (state_next == CT_RUN);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   logic [7:0] loadCode_d;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         loadCode_d <= 8'h00;
      end else begin
         loadCode_d <= loadCode;
      end
   end

   sequence s_bootAuto;
      state_reg == CT_BOOT && autoMode && switchStart && !cmd[CMD_RESTART];
   endsequence
   sequence s_runEntered;
      state_reg == CT_RUN && programRun && startPulse ##1 !startPulse;
   endsequence

   a_run_lamp_off: assert property ((cond.sysErr || cond.cpuFault) |=> !lamp.run)
      else $error("Run lamp lit during fault");
   a_prog_steady: assert property ((running && !waiting) |=> lamp.prog && statusWord[SW_RUN])
      else $error("Running program not shown");
   a_wait_flag: assert property ((running && cond.waitInput) |=> !statusWord[SW_RUN])
      else $error("Run flag set during input wait");
   a_dark_boot: assert property ((!attn_reg && !running && !cond.xferWait) |=> !lamp.prog)
      else $error("Program lamp lit before attention key");
   a_err_flag: assert property ((anyErr && !cond.memCorrupt) |=> lamp.err && statusWord[SW_ERR])
      else $error("Error not shown");
   a_batt_flag: assert property (cond.battLow |=> statusWord[SW_BATT])
      else $error("Battery flag missing");
   a_rx1_flag: assert property ((cond.rxErr[0] && !cond.memCorrupt) |=>
      statusWord[SW_RX1] && lamp.portErr[0])
      else $error("Port 1 error not shown");
   a_rx2_flag: assert property ((cond.rxErr[1] && !cond.memCorrupt) |=>
      statusWord[SW_RX2] && lamp.portErr[1])
      else $error("Port 2 error not shown");
   a_term_flag: assert property ((cond.rxErr[2] && !cond.memCorrupt) |=>
      statusWord[SW_TERM] == THREE_PORT && lamp.portErr[2] == THREE_PORT)
      else $error("Terminal port error not shown");
   a_mem_flash: assert property (cond.memCorrupt |=> lamp.portErr[0] == lamp.err)
      else $error("Error lamps not flashing together");
   a_load_code: assert property ((state_reg == CT_BOOT) |=> loadPulse == (loadCode_d == CODE_ENABLE))
      else $error("Load decision wrong");
   a_auto_start: assert property (s_bootAuto |=> s_runEntered)
      else $error("Automatic start missed");
   a_stop_refuse: assert property (!switchStart |=> state_reg != CT_RUN)
      else $error("Program run with switch at stop");
   a_halt_key: assert property ((running && cmd[CMD_ATTN]) |=>
      state_reg != CT_RUN && !programRun)
      else $error("Attention key did not halt");
   a_halt_line: assert property ((running && cond.breakHit) |=> !programRun)
      else $error("Breakpoint did not halt");
endmodule
`default_nettype wire

/* testbench/ssc_host_model.sv */
// Host controller and operator terminal model: APB master for setup words and commands.
// Assumes an APB slave on the same clock that may insert wait states.
`timescale 1ns/1ps
`default_nettype none
module ssc_host_model
   import ssc_pkg::*;
(
   input wire logic clk,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [11:0] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h00000000;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // Held until pready is seen; released address and data lines are inverted so stale values never help
   task xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
             output logic [31:0] q, output logic e);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) begin
         @(posedge clk);
      end
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      paddr <= ~a;
      pwdata <= ~d;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Terminal run request; the caller owns the switch position
   task runCmd();
      logic [31:0] q;
      logic e;
      xfer(1'b1, OFS_COMMAND, 32'h1 << CMD_RUN, q, e);
   endtask
endmodule
`default_nettype wire

/* testbench/ssc_status_ctl_tb.sv */
// Self-checking bench for the lamp, status word and startup controller.
// Assumes the host model as APB master; flash counts shortened by parameter.
`timescale 1ns/1ps
`default_nettype none
module ssc_status_ctl_tb
   import ssc_pkg::*;
;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic switchStart = 1'b0;
   ssc_cond_s cond = '0;
   logic psel, penable, pwrite, pready, pslverr, programRun, startPulse, loadPulse;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   ssc_lamp_s lamp;
   logic [15:0] statusWord;
   logic startSeen = 1'b0;
   logic loadSeen = 1'b0;
   logic probe;
   int error_cnt = 0;
   int compares = 0;
   int sel = 0;
   always #12.5 clk = ~clk;
   assign probe = (sel == 0) ? lamp.prog : (sel == 1) ? lamp.err : lamp.portAct[sel-2];
   // Pulses last one cycle, so they are latched for later checks
   always @(posedge clk) begin
      if (startPulse) startSeen <= 1'b1;
      if (loadPulse) loadSeen <= 1'b1;
   end
   ssc_status_ctl #(.THREE_PORT(1'b1), .FAST_CYC(4), .SLOW_DIV(5)) i_dut (.clk(clk),
      .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .switchStart(switchStart), .cond(cond), .lamp(lamp), .statusWord(statusWord),
      .programRun(programRun), .startPulse(startPulse), .loadPulse(loadPulse));
   ssc_host_model i_host (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   ////////////////////////////////////////////////////////////////////////////////
   task chk(input logic ok, input string msg);
      compares++;
      if (ok !== 1'b1) begin
         error_cnt++;
         $display("[FAIL] %0t %s", $time, msg);
      end
   endtask
   task tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      i_host.xfer(1'b1, a, d, q, e);
   endtask
   task rd(input logic [11:0] a, output logic [31:0] q, output logic e);
      i_host.xfer(1'b0, a, 32'h00000000, q, e);
   endtask
   task end_sim();
      $display("checks %0d mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // Counts lamp toggles over 40 cycles: fast flash about 10, slow about 2
   task flash(input int s, input int lo, input int hi);
      int c;
      logic p;
      sel = s;
      c = 0;
      tick(1);
      p = probe;
      repeat (40) begin
         tick(1);
         if (probe !== p) c++;
         p = probe;
      end
      chk(c >= lo && c <= hi, "flash rate");
   endtask
   task startRun();
      @(posedge clk) switchStart <= 1'b0;
      @(posedge clk) switchStart <= 1'b1;
      tick(3);
      chk(programRun === 1'b1, "switch start");
      chk(statusWord[SW_RUN] === 1'b1 && lamp.prog === 1'b1, "run flag");
   endtask
   task setErr(input int i, input logic v);
      case (i)
         0: cond.sysErr <= v;
         1: cond.progErr <= v;
         2: cond.rxErr[0] <= v;
         3: cond.rxErr[1] <= v;
         4: cond.rxErr[2] <= v;
         default: cond.battLow <= v;
      endcase
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      $display("[FAIL] %0t timeout", $time);
      end_sim();
   end
   initial begin
      logic [31:0] q;
      logic e;
      int bits [6];
      bits = '{SW_ERR, SW_ERR, SW_RX1, SW_RX2, SW_TERM, SW_BATT};
      repeat (6) @(posedge clk);
      chk(statusWord === 16'h0000 && programRun === 1'b0, "reset outputs");
      rst_b <= 1'b1;
      tick(3);
      chk(lamp.run === 1'b1, "run lamp");
      flash(0, 0, 0);
      rd(OFS_SETUP_M, q, e);
      chk(q === 32'h00000000 && e === 1'b0, "setup reset");
      rd(12'h010, q, e);
      chk(q === 32'h00000000 && e === 1'b1, "unmapped read");
      @(posedge clk) cond.xferWait <= 1'b1;
      flash(0, 8, 11);
      @(posedge clk) cond.xferWait <= 1'b0;
      wr(OFS_COMMAND, 32'h1 << CMD_ATTN);
      flash(0, 1, 3);
      for (int i = 0; i < 3; i++) begin
         @(posedge clk) cond.portActive[i] <= 1'b1;
         flash(2 + i, 8, 11);
         @(posedge clk) cond.portActive[i] <= 1'b0;
      end
      $display("test lamps done");
      startRun();
      @(posedge clk) cond.waitInput <= 1'b1;
      tick(2);
      chk(statusWord[SW_RUN] === 1'b0, "input wait flag");
      flash(0, 1, 3);
      @(posedge clk) cond.waitInput <= 1'b0;
      {cond.waitCmd, cond.waitSend} <= 2'b11;
      tick(2);
      chk(statusWord[SW_RUN] === 1'b1, "command wait flag");
      @(posedge clk) {cond.waitCmd, cond.waitSend, cond.waitPrint} <= 3'b001;
      tick(2);
      chk(statusWord[SW_RUN] === 1'b0 && programRun === 1'b1, "print wait flag");
      @(posedge clk) cond.waitPrint <= 1'b0;
      for (int i = 0; i < 5; i++) begin
         startRun();
         @(posedge clk);
         case (i)
            0: cond.breakHit <= 1'b1;
            1: cond.stopStmt <= 1'b1;
            2: cond.runToHit <= 1'b1;
            4: switchStart <= 1'b0;
            default: wr(OFS_COMMAND, 32'h1 << CMD_ATTN);
         endcase
         @(posedge clk);
         cond.breakHit <= 1'b0;
         cond.stopStmt <= 1'b0;
         cond.runToHit <= 1'b0;
         tick(1);
         chk(programRun === 1'b0, "halt");
      end
      i_host.runCmd();
      tick(2);
      chk(programRun === 1'b0, "run at stop");
      startRun();
      wr(OFS_COMMAND, 32'h1 << CMD_ATTN);
      i_host.runCmd();
      tick(2);
      chk(programRun === 1'b1, "run command");
      @(posedge clk) switchStart <= 1'b0;
      $display("test run control done");
      for (int i = 0; i < 6; i++) begin
         @(posedge clk) setErr(i, 1'b1);
         tick(2);
         chk(statusWord === (16'h0001 << bits[i]), "status word");
         chk(i < 2 ? lamp.err === 1'b1 : i < 5 ? lamp.portErr[i-2] === 1'b1 : 1'b1,
             "lamp");
         rd(OFS_STATUS, q, e);
         chk(q === (32'h00000001 << bits[i]), "status read");
         if (i == 5) flash(1, 1, 3);
         @(posedge clk) setErr(i, 1'b0);
      end
      @(posedge clk) cond.memCorrupt <= 1'b1;
      flash(1, 1, 3);
      repeat (25) begin
         tick(1);
         chk(lamp.portErr === {3{lamp.err}}, "corrupt lamps");
      end
      @(posedge clk) cond.memCorrupt <= 1'b0;
      $display("test errors done");
      wr(OFS_SETUP_M, 32'h00005a00);
      wr(OFS_SETUP_M1, 32'h0000005a);
      @(posedge clk) switchStart <= 1'b1;
      tick(3);
      @(posedge clk) startSeen <= 1'b0;
      loadSeen <= 1'b0;
      wr(OFS_COMMAND, 32'h1 << CMD_RESTART);
      tick(4);
      chk(loadSeen === 1'b1 && startSeen === 1'b1 && programRun === 1'b1, "auto");
      wr(OFS_SETUP_M, 32'h00000000);
      wr(OFS_SETUP_M1, 32'h00000000);
      @(posedge clk) startSeen <= 1'b0;
      loadSeen <= 1'b0;
      wr(OFS_COMMAND, 32'h1 << CMD_RESTART);
      tick(4);
      chk(loadSeen === 1'b0 && startSeen === 1'b0 && programRun === 1'b0, "manual");
      wr(OFS_SETUP_M1, 32'h00000033);
      wr(OFS_COMMAND, 32'h1 << CMD_RESTART);
      tick(4);
      chk(lamp.run === 1'b0 && programRun === 1'b0, "bad mode");
      wr(OFS_SETUP_M1, 32'h0000005a);
      @(posedge clk) switchStart <= 1'b0;
      wr(OFS_COMMAND, 32'h1 << CMD_RESTART);
      tick(4);
      chk(programRun === 1'b0 && lamp.run === 1'b1, "auto at stop");
      for (int i = 0; i < 2; i++) begin
         @(posedge clk) {cond.hostPowerOff, cond.cpuFault} <= 2'b10 >> i;
         tick(2);
         chk(lamp.run === 1'b0, "fault run lamp");
      end
      @(posedge clk) cond.cpuFault <= 1'b0;
      tick(2);
      chk(lamp.run === 1'b1, "run lamp back");
      $display("test startup done");
      end_sim();
   end
endmodule
`default_nettype wire
